// [design/tvm_mapper.sv]
// Purpose: one channel between group objects and a modbus register
// Assumes: AXI4-Lite setup, same-clock streams
// Notes: one-cycle events, no back-pressure
// How it works
// R1: compare incoming object with threshold, three outcomes
// R2: bit register: per outcome none, write 1, 0
// R3: register set: optionally send configured object value
// R4: register clear: optionally send other object value
// R5: bit in word: write only selected bit
// R6: selected bit set: optionally send value
// R7: selected bit clear: optionally send other value
// R8: value field given by width and offset
// R9: bus source: write outcome value into field
// R10: modbus source: compare field, send outcome value
// R11: unsigned byte to low, high or field
// R12: configurer keeps width plus offset within 16
// R13: configurer keeps values inside field width
// R14: signed byte to low, high or field
// R15: two byte type uses same three modes
// R16: sixteen-bit register address per channel
// R17: signed field eight bits, sign-extended, truncated
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tvm_cfg.svh"

module tvm_mapper
  import tvm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // group object streams
  input wire tvm_obj_t obj_in,
  output tvm_obj_t obj_out,
  // modbus register streams
  input wire tvm_rd_t reg_rd_in,
  output tvm_wr_t reg_wr_out
);

  // configuration registers
  logic [31:0] ctrl; // type, mode, direction, area, enable
  logic [31:0] addr; // register address
  logic [31:0] thresh; // object threshold
  logic [31:0] field; // width, offset, bit position
  logic [31:0] action; // per outcome actions, send enables
  logic [31:0] regval_a; // gt and eq register values
  logic [31:0] regval_b; // lt register value, register compare value
  logic [31:0] objval_a; // gt and eq object values
  logic [31:0] objval_b; // lt object value
  logic [31:0] objval_c; // set and clear object values

  // mirrored block state
  logic [15:0] shadow; // last known word register content
  logic bit_reg; // last known bit register state
  tvm_cmp_t last_cmp; // latest outcome
  logic [15:0] last_sent; // latest object sent

  // decoded configuration
  tvm_chan_t chan;
  tvm_mode_t mode;
  tvm_pos_t pos;
  logic dir_m2b; // high: modbus is the source
  logic enable;
  logic [4:0] cfg_width;
  logic [3:0] cfg_ofs;
  logic [3:0] bit_pos;

  assign chan = tvm_chan_t'(ctrl[`TVM_CTRL_TYPE_LSB +: 2]);
  assign mode = tvm_mode_t'(ctrl[`TVM_CTRL_MODE_LSB +: 2]);
  assign pos = tvm_pos_t'(ctrl[`TVM_CTRL_POS_LSB +: 2]);
  assign dir_m2b = ctrl[`TVM_CTRL_DIR_BIT];
  assign enable = ctrl[`TVM_CTRL_EN_BIT];
  assign cfg_width = field[`TVM_FIELD_WIDTH_LSB +: 5];
  assign cfg_ofs = field[`TVM_FIELD_OFS_LSB +: 4];
  assign bit_pos = field[`TVM_FIELD_BITPOS_LSB +: 4];

  // three-way unsigned comparison
  function automatic tvm_cmp_t tvm_compare(input logic [15:0] a, input logic [15:0] b);
    if (a > b) begin
      return TVM_CMP_GT;
    end else if (a == b) begin
      return TVM_CMP_EQ;
    end
    return TVM_CMP_LT;
  endfunction

  // byte-lane merge of a write into a register
  function automatic logic [31:0] tvm_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------- axi4-lite write channel ----------------
  logic wr_take; // address and data taken together
  assign wr_take = s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_bvalid_out;
  assign s_axi_awready_out = wr_take;
  assign s_axi_wready_out = wr_take;

  // write response, held until bready
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `TVM_RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid_out <= 1'b1;
      // status words are read only, a write there is an error too
      if (s_axi_awaddr_in[7:2] <= `TVM_OFS_OBJVAL_C >> 2 && s_axi_awaddr_in[1:0] == 2'b00) begin
        s_axi_bresp_out <= `TVM_RESP_OKAY;
      end else begin
        s_axi_bresp_out <= `TVM_RESP_SLVERR;
      end
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // configuration register writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= `TVM_RST_WORD;
      addr <= `TVM_RST_WORD;
      thresh <= `TVM_RST_WORD;
      field <= {27'h000_0000, `TVM_RST_WIDTH};
      action <= `TVM_RST_WORD;
      regval_a <= `TVM_RST_WORD;
      regval_b <= `TVM_RST_WORD;
      objval_a <= `TVM_RST_WORD;
      objval_b <= `TVM_RST_WORD;
      objval_c <= `TVM_RST_WORD;
    end else if (wr_take) begin
      if (s_axi_awaddr_in == `TVM_OFS_CTRL) begin
        ctrl <= tvm_merge(ctrl, s_axi_wdata_in, s_axi_wstrb_in) & 32'h0000_00FF;
      end else if (s_axi_awaddr_in == `TVM_OFS_ADDR) begin
        // address kept to sixteen bits, 0 to 65535
        addr <= tvm_merge(addr, s_axi_wdata_in, s_axi_wstrb_in) & 32'h0000_FFFF; // [R16]
      end else if (s_axi_awaddr_in == `TVM_OFS_THRESH) begin
        thresh <= tvm_merge(thresh, s_axi_wdata_in, s_axi_wstrb_in) & 32'h0000_FFFF;
      end else if (s_axi_awaddr_in == `TVM_OFS_FIELD) begin
        field <= tvm_merge(field, s_axi_wdata_in, s_axi_wstrb_in) & 32'h000F_0F1F;
      end else if (s_axi_awaddr_in == `TVM_OFS_ACTION) begin
        action <= tvm_merge(action, s_axi_wdata_in, s_axi_wstrb_in) & 32'h0000_033F;
      end else if (s_axi_awaddr_in == `TVM_OFS_REGVAL_A) begin
        regval_a <= tvm_merge(regval_a, s_axi_wdata_in, s_axi_wstrb_in);
      end else if (s_axi_awaddr_in == `TVM_OFS_REGVAL_B) begin
        regval_b <= tvm_merge(regval_b, s_axi_wdata_in, s_axi_wstrb_in);
      end else if (s_axi_awaddr_in == `TVM_OFS_OBJVAL_A) begin
        objval_a <= tvm_merge(objval_a, s_axi_wdata_in, s_axi_wstrb_in);
      end else if (s_axi_awaddr_in == `TVM_OFS_OBJVAL_B) begin
        objval_b <= tvm_merge(objval_b, s_axi_wdata_in, s_axi_wstrb_in) & 32'h0000_FFFF;
      end else if (s_axi_awaddr_in == `TVM_OFS_OBJVAL_C) begin
        objval_c <= tvm_merge(objval_c, s_axi_wdata_in, s_axi_wstrb_in);
      end
    end
  end

  // ---------------- axi4-lite read channel ----------------
  assign s_axi_arready_out = ~s_axi_rvalid_out;

  // read data registered, held until rready
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= `TVM_RST_WORD;
      s_axi_rresp_out <= `TVM_RESP_OKAY;
    end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= `TVM_RESP_OKAY;
      if (s_axi_araddr_in == `TVM_OFS_CTRL) begin
        s_axi_rdata_out <= ctrl;
      end else if (s_axi_araddr_in == `TVM_OFS_ADDR) begin
        s_axi_rdata_out <= addr;
      end else if (s_axi_araddr_in == `TVM_OFS_THRESH) begin
        s_axi_rdata_out <= thresh;
      end else if (s_axi_araddr_in == `TVM_OFS_FIELD) begin
        s_axi_rdata_out <= field;
      end else if (s_axi_araddr_in == `TVM_OFS_ACTION) begin
        s_axi_rdata_out <= action;
      end else if (s_axi_araddr_in == `TVM_OFS_REGVAL_A) begin
        s_axi_rdata_out <= regval_a;
      end else if (s_axi_araddr_in == `TVM_OFS_REGVAL_B) begin
        s_axi_rdata_out <= regval_b;
      end else if (s_axi_araddr_in == `TVM_OFS_OBJVAL_A) begin
        s_axi_rdata_out <= objval_a;
      end else if (s_axi_araddr_in == `TVM_OFS_OBJVAL_B) begin
        s_axi_rdata_out <= objval_b;
      end else if (s_axi_araddr_in == `TVM_OFS_OBJVAL_C) begin
        s_axi_rdata_out <= objval_c;
      end else if (s_axi_araddr_in == `TVM_OFS_STATUS) begin
        // live block state: outcome, bit register, word mirror
        s_axi_rdata_out <= {13'h0000, bit_reg, last_cmp, shadow};
      end else if (s_axi_araddr_in == `TVM_OFS_LAST_SENT) begin
        s_axi_rdata_out <= {16'h0000, last_sent};
      end else begin
        // unmapped: zero data and an error
        s_axi_rdata_out <= `TVM_RST_WORD;
        s_axi_rresp_out <= `TVM_RESP_SLVERR;
      end
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ---------------- mapping datapath ----------------
  logic [15:0] obj_val; // object value at the channel width
  logic [15:0] thr_val; // threshold at the channel width
  logic [15:0] cur_word; // freshest view of the word register
  tvm_cmp_t obj_cmp; // object against threshold
  tvm_cmp_t fld_cmp; // register field against compare value
  logic [15:0] fld_word; // word handed to the field unit
  logic [4:0] fld_width;
  logic [3:0] fld_ofs;
  logic [15:0] fld_value;
  logic [15:0] fld_ins;
  logic [15:0] fld_ext;

  // one-byte channels look at the low byte only
  assign obj_val = (chan == TVM_TWO_BYTE_CHANNEL_TYPE) ? obj_in.value :
                   {8'h00, obj_in.value[7:0]}; // [R15]
  assign thr_val = (chan == TVM_TWO_BYTE_CHANNEL_TYPE) ? thresh[15:0] :
                   {8'h00, thresh[7:0]};
  // a read in the same cycle is newer than the mirror
  assign cur_word = reg_rd_in.valid ? reg_rd_in.data : shadow;
  assign obj_cmp = tvm_compare(obj_val, thr_val); // [R1]
  assign fld_cmp = tvm_compare(fld_ext, regval_b[31:16]); // [R10]
  assign fld_word = cur_word;

  // outcome to configured action
  function automatic tvm_act_t tvm_act_of(input tvm_cmp_t c, input logic [31:0] a);
    case (c)
      TVM_CMP_GT: return tvm_act_t'(a[`TVM_ACT_GT_LSB +: 2]);
      TVM_CMP_EQ: return tvm_act_t'(a[`TVM_ACT_EQ_LSB +: 2]);
      default: return tvm_act_t'(a[`TVM_ACT_LT_LSB +: 2]);
    endcase
  endfunction

  // outcome to register value or object value
  function automatic logic [15:0] tvm_val_of(input tvm_cmp_t c, input logic [31:0] ab,
                                             input logic [15:0] lt);
    case (c)
      TVM_CMP_GT: return ab[15:0];
      TVM_CMP_EQ: return ab[31:16];
      default: return lt;
    endcase
  endfunction

  // area select: low byte, high byte, or configured field
  always_comb begin
    fld_value = {8'h00, obj_in.value[7:0]};
    fld_ofs = 4'h0;
    fld_width = `TVM_BYTE_WIDTH;
    if (chan == TVM_ONE_BYTE_CHANNEL_TYPE || chan == TVM_TWO_BYTE_CHANNEL_TYPE) begin
      // value in word: field from width and offset
      fld_width = cfg_width; // [R8]
      fld_ofs = cfg_ofs;
      fld_value = tvm_val_of(obj_cmp, regval_a, regval_b[15:0]); // [R9]
    end else if (pos == TVM_POS_HIGH) begin
      fld_ofs = `TVM_HIGH_OFS; // [R11] [R14]
    end else if (pos == TVM_POS_FIELD) begin
      fld_ofs = cfg_ofs;
      // signed field always eight bits wide
      fld_width = (chan == TVM_SIGNED_BYTE_CHANNEL_TYPE) ? `TVM_BYTE_WIDTH : cfg_width; // [R17]
    end
  end

  tvm_field u_field (
    .word_in(fld_word),
    .width_in(fld_width),
    .offset_in(fld_ofs),
    .value_in(fld_value),
    .inserted_out(fld_ins),
    .extracted_out(fld_ext)
  );

  logic [15:0] next_shadow;
  logic next_bit;
  logic wr_go; // issue a register write
  logic [15:0] wr_data;
  logic send_go; // send an object value
  logic [15:0] send_val;
  logic sel_bit; // register bit that the modbus side reports
  tvm_act_t act;

  // event handling for both directions
  always_comb begin
    next_shadow = cur_word;
    next_bit = reg_rd_in.valid ? reg_rd_in.data[0] : bit_reg;
    wr_go = 1'b0;
    wr_data = cur_word;
    send_go = 1'b0;
    send_val = 16'h0000;
    act = tvm_act_of(obj_cmp, action);
    sel_bit = (mode == TVM_BIT_REG) ? reg_rd_in.data[0] : reg_rd_in.data[bit_pos];
    if (enable && !dir_m2b && obj_in.valid) begin
      if (chan == TVM_ONE_BYTE_CHANNEL_TYPE || chan == TVM_TWO_BYTE_CHANNEL_TYPE) begin
        case (mode)
          TVM_BIT_REG: begin
            // write 1 or 0, or leave alone
            if (act == TVM_ACT_ONE || act == TVM_ACT_ZERO) begin
              next_bit = (act == TVM_ACT_ONE); // [R2]
              wr_go = 1'b1;
              wr_data = {15'h0000, act == TVM_ACT_ONE};
            end
          end
          TVM_BIT_IN_WORD: begin
            // read-modify-write on the mirror touches one bit only
            if (act == TVM_ACT_ONE || act == TVM_ACT_ZERO) begin
              next_shadow[bit_pos] = (act == TVM_ACT_ONE); // [R5]
              wr_go = 1'b1;
              wr_data = next_shadow;
            end
          end
          TVM_VALUE_IN_WORD: begin
            // any action other than none sets the value
            if (act != TVM_ACT_NONE) begin
              next_shadow = fld_ins; // [R9]
              wr_go = 1'b1;
              wr_data = fld_ins;
            end
          end
          default: begin
            wr_go = 1'b0;
          end
        endcase
      end else begin
        // plain byte transfers always write
        next_shadow = fld_ins; // [R11] [R14]
        wr_go = 1'b1;
        wr_data = fld_ins;
      end
    end else if (enable && dir_m2b && reg_rd_in.valid) begin
      if (chan == TVM_ONE_BYTE_CHANNEL_TYPE || chan == TVM_TWO_BYTE_CHANNEL_TYPE) begin
        if (mode == TVM_BIT_REG || mode == TVM_BIT_IN_WORD) begin
          if (sel_bit && action[`TVM_ACT_SET_BIT]) begin
            send_go = 1'b1; // [R3] [R6]
            send_val = objval_c[15:0];
          end else if (!sel_bit && action[`TVM_ACT_CLR_BIT]) begin
            send_go = 1'b1; // [R4] [R7]
            send_val = objval_c[31:16];
          end
        end else if (mode == TVM_VALUE_IN_WORD) begin
          send_go = (tvm_act_of(fld_cmp, action) != TVM_ACT_NONE); // [R10]
          send_val = tvm_val_of(fld_cmp, objval_a, objval_b[15:0]);
        end
        if (chan == TVM_ONE_BYTE_CHANNEL_TYPE) begin
          send_val = {8'h00, send_val[7:0]};
        end
      end else if (chan == TVM_SIGNED_BYTE_CHANNEL_TYPE) begin
        send_go = 1'b1;
        send_val = {{8{fld_ext[7]}}, fld_ext[7:0]}; // [R14] [R17]
      end else begin
        send_go = 1'b1;
        send_val = {8'h00, fld_ext[7:0]}; // [R11]
      end
    end
  end

  // mirrors follow reads and own writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow <= 16'h0000;
      bit_reg <= 1'b0;
    end else begin
      shadow <= next_shadow;
      bit_reg <= next_bit;
    end
  end

  // latest outcome of whichever comparison ran
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_cmp <= TVM_CMP_NONE;
    end else if (enable && !dir_m2b && obj_in.valid) begin
      last_cmp <= obj_cmp; // [R1]
    end else if (enable && dir_m2b && reg_rd_in.valid && mode == TVM_VALUE_IN_WORD) begin
      last_cmp <= fld_cmp;
    end
  end

  // register write request, one-cycle pulse
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_wr_out <= '0;
    end else begin
      reg_wr_out.valid <= wr_go;
      reg_wr_out.is_bit <= (mode == TVM_BIT_REG) &&
                           (chan == TVM_ONE_BYTE_CHANNEL_TYPE || chan == TVM_TWO_BYTE_CHANNEL_TYPE);
      reg_wr_out.addr <= addr[15:0]; // [R16]
      if (wr_go) begin
        reg_wr_out.data <= wr_data;
      end
    end
  end

  // object send, one-cycle pulse, value held
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      obj_out <= '0;
      last_sent <= 16'h0000;
    end else begin
      obj_out.valid <= send_go;
      if (send_go) begin
        obj_out.value <= send_val;
        last_sent <= send_val;
      end
    end
  end

endmodule

`default_nettype wire

// [design/tvm_cfg.svh]
// Purpose: offsets, fields and reset values of the mapper
// Assumes: included by bare name
// Notes: definitions only
`ifndef TVM_CFG_SVH
`define TVM_CFG_SVH

// byte offsets, one word each
`define TVM_OFS_CTRL 8'h00
`define TVM_OFS_ADDR 8'h04
`define TVM_OFS_THRESH 8'h08
`define TVM_OFS_FIELD 8'h0C
`define TVM_OFS_ACTION 8'h10
`define TVM_OFS_REGVAL_A 8'h14
`define TVM_OFS_REGVAL_B 8'h18
`define TVM_OFS_OBJVAL_A 8'h1C
`define TVM_OFS_OBJVAL_B 8'h20
`define TVM_OFS_OBJVAL_C 8'h24
`define TVM_OFS_STATUS 8'h28
`define TVM_OFS_LAST_SENT 8'h2C

// control word fields
`define TVM_CTRL_TYPE_LSB 0
`define TVM_CTRL_MODE_LSB 2
`define TVM_CTRL_DIR_BIT 4
`define TVM_CTRL_POS_LSB 5
`define TVM_CTRL_EN_BIT 7

// field word fields
`define TVM_FIELD_WIDTH_LSB 0
`define TVM_FIELD_OFS_LSB 8
`define TVM_FIELD_BITPOS_LSB 16

// action word fields
`define TVM_ACT_GT_LSB 0
`define TVM_ACT_EQ_LSB 2
`define TVM_ACT_LT_LSB 4
`define TVM_ACT_SET_BIT 8
`define TVM_ACT_CLR_BIT 9

// reset values, byte width and high byte offset
`define TVM_RST_WORD 32'h0000_0000
`define TVM_RST_WIDTH 5'h10
`define TVM_BYTE_WIDTH 5'h08
`define TVM_HIGH_OFS 4'h8

// axi responses
`define TVM_RESP_OKAY 2'b00
`define TVM_RESP_SLVERR 2'b10

`endif

// [design/tvm_pkg.sv]
// Purpose: mapper types
// Assumes: nothing
// Notes: carriers are packed structs
package tvm_pkg;

  // channel types
  typedef enum logic [1:0] {
    TVM_ONE_BYTE_CHANNEL_TYPE = 2'h0,
    TVM_TWO_BYTE_CHANNEL_TYPE = 2'h1,
    TVM_UNSIGNED_BYTE = 2'h2,
    TVM_SIGNED_BYTE_CHANNEL_TYPE = 2'h3
  } tvm_chan_t;

  // register mapping modes
  typedef enum logic [1:0] {
    TVM_BIT_REG = 2'h0,
    TVM_BIT_IN_WORD = 2'h1,
    TVM_VALUE_IN_WORD = 2'h2,
    TVM_MODE_SPARE = 2'h3
  } tvm_mode_t;

  // word area selection for byte transfers
  typedef enum logic [1:0] {
    TVM_POS_LOW = 2'h0,
    TVM_POS_HIGH = 2'h1,
    TVM_POS_FIELD = 2'h2,
    TVM_POS_SPARE = 2'h3
  } tvm_pos_t;

  // per outcome action
  typedef enum logic [1:0] {
    TVM_ACT_NONE = 2'h0,
    TVM_ACT_ONE = 2'h1,
    TVM_ACT_ZERO = 2'h2,
    TVM_ACT_SPARE = 2'h3
  } tvm_act_t;

  // comparison outcome
  typedef enum logic [1:0] {
    TVM_CMP_LT = 2'h0,
    TVM_CMP_EQ = 2'h1,
    TVM_CMP_GT = 2'h2,
    TVM_CMP_NONE = 2'h3
  } tvm_cmp_t;

  // group object value, either direction
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } tvm_obj_t;

  // modbus register read result
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } tvm_rd_t;

  // modbus register write request
  typedef struct packed {
    logic valid;
    logic is_bit;
    logic [15:0] addr;
    logic [15:0] data;
  } tvm_wr_t;

endpackage

// [design/tvm_field.sv]
// Purpose: 16-bit word field insert and extract
// Assumes: width plus offset within 16, caller keeps value inside width
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "tvm_cfg.svh"

module tvm_field
  import tvm_pkg::*;
(
  input wire logic [15:0] word_in,
  input wire logic [4:0] width_in,
  input wire logic [3:0] offset_in,
  input wire logic [15:0] value_in,
  output logic [15:0] inserted_out,
  output logic [15:0] extracted_out
);

  // right aligned mask of the field width
  function automatic logic [15:0] tvm_mask(input logic [4:0] w);
    logic [16:0] full;
    full = (17'h0_0001 << w) - 17'h0_0001;
    return full[15:0];
  endfunction

  logic [15:0] mask; // field mask before shifting

  // width 16 makes full mask, zero gives an empty field
  assign mask = tvm_mask(width_in);
  // only the field bits change, the rest of the word is kept
  assign inserted_out = (word_in & ~(mask << offset_in)) | ((value_in & mask) << offset_in);
  assign extracted_out = (word_in >> offset_in) & mask;

endmodule

`default_nettype wire

// [sim/tvm_modbus_model.sv]
// Purpose: modbus register model
// Assumes: one word at the channel address
// Notes: a poll answers one cycle later
`timescale 1ns/100ps
`default_nettype none
module tvm_modbus_model
  import tvm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire tvm_wr_t wr_in,
  input wire tvm_rd_t seed_in,
  input wire logic poll_in,
  output tvm_rd_t rd_out
);
  logic [15:0] word; // register contents
  // bench seed wins over a mapper write; bit mode keeps bit 0
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) word <= 16'h0000;
    else if (seed_in.valid) word <= seed_in.data;
    else if (wr_in.valid) word <= wr_in.is_bit ? {15'h0000, wr_in.data[0]} : wr_in.data;
  end
  // idle data inverted so a stale word never passes as fresh
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rd_out <= '0;
    else rd_out <= poll_in ? {1'b1, word} : {1'b0, ~rd_out.data};
  end
endmodule
`default_nettype wire

// [sim/tvm_mapper_properties.sv]
// Purpose: mapper port assertions
// Assumes: one clock, async active-low reset
// Notes: bound to the mapper below
`timescale 1ns/100ps
`default_nettype none
module tvm_mapper_properties
  import tvm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire tvm_obj_t obj_in,
  input wire tvm_obj_t obj_out,
  input wire tvm_rd_t reg_rd_in,
  input wire tvm_wr_t reg_wr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wr_answer_a: assert property (s_axi_awvalid_in && s_axi_wvalid_in && s_axi_awready_out
    |=> s_axi_bvalid_out) else $error("write answer late");
  wr_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  rd_stable_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data moved");
  map_cause_a: assert property (reg_wr_out.valid |-> $past(obj_in.valid))
    else $error("write without object");
  send_cause_a: assert property (obj_out.valid |-> $past(reg_rd_in.valid))
    else $error("send without read");
  bit_data_a: assert property (reg_wr_out.valid && reg_wr_out.is_bit
    |-> reg_wr_out.data[15:1] == 15'h0000) else $error("bit write not 0 or 1");
  send_hold_a: assert property (!obj_out.valid |-> $stable(obj_out.value))
    else $error("sent value moved");
  cover property (reg_wr_out.valid && reg_wr_out.is_bit);
  cover property (reg_wr_out.valid && !reg_wr_out.is_bit);
  cover property (obj_out.valid);
endmodule
bind tvm_mapper tvm_mapper_properties u_tvm_mapper_properties (.clk_in, .rst_n_in,
  .s_axi_awvalid_in, .s_axi_wvalid_in, .s_axi_awready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out,
  .obj_in, .obj_out, .reg_rd_in, .reg_wr_out);
`default_nettype wire

// [sim/testbench.sv]
// Purpose: mapper bench
// Assumes: mapper register map
// Notes: modbus model at far side
`timescale 1ns/100ps
`default_nettype none
module testbench
  import tvm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, poll = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  tvm_obj_t obj_i = '0, obj_o;
  tvm_rd_t rd, seed = '0;
  tvm_wr_t wr;
  int error_cnt = 0, tests_run = 0, n;
  tvm_mapper u_tvm_mapper (.clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .obj_in(obj_i), .obj_out(obj_o), .reg_rd_in(rd), .reg_wr_out(wr));
  tvm_modbus_model u_tvm_modbus_model (.clk_in(clk), .rst_n_in(rst_n), .wr_in(wr),
    .seed_in(seed), .poll_in(poll), .rd_out(rd));
  // 40 mhz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // bounded handshake wait
  task automatic hs(ref logic s);
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s === 1'b1) break;
    end
    if (n >= 40) begin
      error_cnt++;
      conclude();
    end
  endtask
  // axi write, aw and w together
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hs(wready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hs(bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic r(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hs(arready);
    arvalid <= 1'b0;
    hs(rvalid);
    rready <= 1'b0;
    chk("rdata", e, {rresp, rdata});
  endtask
  // object pulse, write due next cycle
  task automatic ev(input logic [15:0] v, input tvm_wr_t e);
    @(posedge clk);
    obj_i <= {1'b1, v};
    @(posedge clk);
    obj_i <= {1'b0, v};
    #1 chk("reg_wr", e, wr.valid ? wr : '0);
  endtask
  // seed, poll, expect the send
  task automatic pl(input logic [15:0] v, input tvm_obj_t e);
    @(posedge clk);
    seed <= {1'b1, v};
    @(posedge clk);
    seed <= {1'b0, v};
    poll <= 1'b1;
    @(posedge clk);
    poll <= 1'b0;
    @(posedge clk);
    #1 chk("obj_out", e, obj_o.valid ? obj_o : '0);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    r(8'h0C, {2'b00, 32'h0000_0010});
    r(8'h30, {2'b10, 32'h0000_0000});
    w(8'h28, 32'h0000_FFFF, 2'b10);
    w(8'h04, 32'h0000_FFFF);
    w(8'h08, 32'h0000_0040);
    w(8'h10, 32'h0000_0009);
    w(8'h00, 32'h0000_0080);
    ev(16'h0050, {2'b11, 16'hFFFF, 16'h0001});
    ev(16'h0040, {2'b11, 16'hFFFF, 16'h0000});
    ev(16'h0110, '0);
    w(8'h24, 32'h0022_0011);
    w(8'h10, 32'h0000_0300);
    w(8'h00, 32'h0000_0090);
    pl(16'h0001, {1'b1, 16'h0011});
    pl(16'h0000, {1'b1, 16'h0022});
    w(8'h0C, 32'h0005_0010);
    w(8'h08, 32'h0000_1000);
    w(8'h10, 32'h0000_0021);
    w(8'h00, 32'h0000_0085);
    pl(16'h1200, '0);
    ev(16'h2000, {2'b10, 16'hFFFF, 16'h1220});
    ev(16'h0800, {2'b10, 16'hFFFF, 16'h1200});
    w(8'h10, 32'h0000_0321);
    w(8'h00, 32'h0000_0095);
    pl(16'h1220, {1'b1, 16'h0011});
    pl(16'h1200, {1'b1, 16'h0022});
    w(8'h0C, 32'h0000_0404);
    w(8'h14, 32'h0005_000A);
    w(8'h10, 32'h0000_0005);
    w(8'h00, 32'h0000_0089);
    ev(16'h2000, {2'b10, 16'hFFFF, 16'h12A0});
    ev(16'h1000, {2'b10, 16'hFFFF, 16'h1250});
    w(8'h18, 32'h0003_0000);
    w(8'h1C, 32'h0222_0111);
    w(8'h20, 32'h0000_0333);
    w(8'h10, 32'h0000_0015);
    w(8'h00, 32'h0000_0099);
    pl(16'h0050, {1'b1, 16'h0111});
    pl(16'h0030, {1'b1, 16'h0222});
    pl(16'h0F1F, {1'b1, 16'h0333});
    w(8'h00, 32'h0000_00A2);
    ev(16'h00AB, {2'b10, 16'hFFFF, 16'hAB1F});
    w(8'h0C, 32'h0000_0400);
    w(8'h00, 32'h0000_00D3);
    pl(16'h0F80, {1'b1, 16'hFFF8});
    r(8'h28, {2'b00, 32'h0002_0F80});
    conclude();
  end
endmodule
`default_nettype wire
